//--- shared/spc_defs.svh
// Purpose: Offsets, field positions and reset values of the serial port control block
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   Definitions only
`ifndef SPC_DEFS_SVH
`define SPC_DEFS_SVH

`define SPC_AW          8
`define SPC_DW          32
`define SPC_OFS_CTRL    8'h00
`define SPC_OFS_MODE    8'h04
`define SPC_OFS_STATE   8'h08
`define SPC_OFS_ISTAT   8'h0c
`define SPC_OFS_IEN     8'h10
`define SPC_OFS_ICLR    8'h14

`define SPC_BIT_TIE     7
`define SPC_BIT_RIE     6
`define SPC_BIT_TE      5
`define SPC_BIT_RE      4
`define SPC_BIT_MULTIPROC_WAKEUP_ENABLE    3
`define SPC_BIT_TX_END_IRQ_ENABLE    2
`define SPC_BIT_CLOCK_SOURCE_HI    1
`define SPC_BIT_CLOCK_SOURCE_LO    0
`define SPC_CTRL_W      8
`define SPC_CTRL_RST    8'h00

`define SPC_MODE_COM    0
`define SPC_MODE_MP     1
`define SPC_MODE_W      2
`define SPC_MODE_RST    2'h0

`define SPC_CKS_INT     2'h0
`define SPC_CKS_INT_OUT 2'h1
`define SPC_CKS_EXT     2'h2

`define SPC_NEV         4
`define SPC_EV_TXE      0
`define SPC_EV_RXF      1
`define SPC_EV_RXE      2
`define SPC_EV_TXEND    3

`define SPC_ST_MPB      0
`define SPC_ST_TXE      1
`define SPC_ST_TXEND    2
`define SPC_ST_EXT      3
`define SPC_ST_W        4

`endif

//--- shared/spc_pkg.sv
// Purpose: Types shared by the serial port control modules
// Assumes: Nothing beyond the defs header
// Notes:   Enums carry no codes
package spc_pkg;
    typedef enum logic [1:0] {SCK_INT_ONLY, SCK_INT_DRIVE, SCK_EXT_IN} sck_role_t;
    typedef enum logic {COMM_ASYNC, COMM_SYNC} comm_mode_t;
    typedef enum logic {APB_SETUP, APB_ANSWER} apb_state_t;
endpackage

//--- logic/spc_irq_unit.sv
// Purpose: Sticky event status, enable and clear with one level interrupt
// Assumes: Events are same-clock pulses or levels
// Notes:   A set in the cycle of a clear wins
module spc_irq_unit #(
    parameter int N = 4
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         ce,
    // Events and software access
    input  wire logic [N-1:0] set_ev,
    input  wire logic         en_wr,
    input  wire logic         clr_wr,
    input  wire logic [N-1:0] wdata,
    // State
    output logic      [N-1:0] status_q,
    output logic      [N-1:0] enable_q,
    output logic              irq_q
);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            enable_q <= '0;
        end else if (ce && en_wr) begin
            enable_q <= wdata;
        end
    end

    for (genvar i = 0; i < N; i++) begin : g_stat
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                status_q[i] <= 1'b0;
            end else if (ce) begin
                if (set_ev[i]) begin
                    status_q[i] <= 1'b1;
                end else if (clr_wr && wdata[i]) begin
                    status_q[i] <= 1'b0;
                end
            end
        end

        set_wins_a: assert property (@(posedge clk) disable iff (!rst_n)
            ce && set_ev[i] |=> status_q[i])
            else $error("event lost against a clear");
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
        end else if (ce) begin
            irq_q <= |(status_q & enable_q);
        end
    end
endmodule

//--- logic/spc_sck_unit.sv
// Purpose: Serial clock pin driver and receiver, transfer clock ticks
// Assumes: bit_tick pulses twice per bit period from the rate generator
// Notes:   Pin input passes two flops before use
module spc_sck_unit (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire logic               ce,
    // Control
    input  wire spc_pkg::sck_role_t role,
    input  wire logic               bit_tick,
    // Pin
    input  wire logic               sck_i,
    output logic                    sck_o,
    output logic                    sck_oe,
    // Transfer clock
    output logic                    xfer_tick
);
    import spc_pkg::*;

    logic meta_q, sync_q, prev_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            // Idle-high reset, so no false pin edge after reset
            meta_q <= 1'b1;
            sync_q <= 1'b1;
            prev_q <= 1'b1;
        end else if (ce) begin
            meta_q <= sck_i;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sck_o     <= 1'b1;
            sck_oe    <= 1'b0;
            xfer_tick <= 1'b0;
        end else if (ce) begin
            sck_oe    <= (role == SCK_INT_DRIVE);
            if (role == SCK_EXT_IN) begin
                sck_o     <= 1'b1;
                xfer_tick <= sync_q && !prev_q;
            end else begin
                // Toggle per half bit gives one clock per bit
                if (bit_tick) begin
                    sck_o <= !sck_o;
                end
                xfer_tick <= bit_tick;
            end
        end
    end

    pin_input_a: assert property (@(posedge clk) disable iff (!rst_n)
        ce && role == SCK_EXT_IN |=> !sck_oe)
        else $error("pin driven while clock is external");
    pin_drive_a: assert property (@(posedge clk) disable iff (!rst_n)
        ce && role == SCK_INT_DRIVE |=> sck_oe)
        else $error("pin not driven while clock is internal");
    ext_tick_c: cover property (@(posedge clk) disable iff (!rst_n)
        role == SCK_EXT_IN && xfer_tick);
endmodule

//--- logic/serial_port_control.sv
// Purpose: Control register of the serial interface unit with APB access
// Assumes: Framing logic and rate generator share CORE_CLK
// Notes:   One wait state per APB transfer; pin clock is synchronised
`include "spc_defs.svh"

// Function
// - Transmit empty request needs its enable
// - Receive full and error need receive interrupt enable
// - Transmission only while transmitter enabled
// - Reception only while receiver enabled
// - Wake-up filter only async multiprocessor mode
// - Filter drops characters with clear multiprocessor bit
// - Set multiprocessor bit clears filter, resumes reception
// - Transmit end request needs its enable
// - Async code 00 uses internal generator
// - Async code 01 also drives pin clock
// - Async code 10 takes sixteen-times pin clock
// - Sync code 00 drives internal clock out
// - Sync code 10 takes clock from pin
// - Mode bit selects async or sync encoding
// - Received multiprocessor bit held while receiver off
module serial_port_control (
    // Clock, enable and reset
    input  wire logic                 CORE_CLK,
    input  wire logic                 RST_N,
    input  wire logic                 CE,
    // APB slave
    input  wire logic [`SPC_AW-1:0]   PADDR,
    input  wire logic                 PSEL,
    input  wire logic                 PENABLE,
    input  wire logic                 PWRITE,
    input  wire logic [`SPC_DW-1:0]   PWDATA,
    output logic      [`SPC_DW-1:0]   PRDATA,
    output logic                      PREADY,
    output logic                      PSLVERR,
    // Transmit side status
    input  wire logic                 TX_EMPTY,
    input  wire logic                 TX_END,
    // Receive side events and flags
    input  wire logic                 RX_DONE,
    input  wire logic                 RX_MPB,
    input  wire logic                 RX_FER,
    input  wire logic                 RX_OVR,
    input  wire logic                 RX_FULL_LVL,
    input  wire logic                 RX_ERR_LVL,
    // Rate generator
    input  wire logic                 BIT_TICK,
    // Serial clock pin
    input  wire logic                 SCK_I,
    output logic                      SCK_O,
    output logic                      SCK_OE,
    // Framing control
    output logic                      TX_ENABLE,
    output logic                      RX_ENABLE,
    output logic                      XFER_TICK,
    output logic                      CLK_EXTERNAL,
    output logic                      RX_FULL_SET,
    output logic                      FER_SET,
    output logic                      OVR_SET,
    // Interrupt requests
    output logic                      TX_EMPTY_IRQ,
    output logic                      RX_FULL_IRQ,
    output logic                      RX_ERROR_IRQ,
    output logic                      TX_END_IRQ,
    output logic                      IRQ
);
    import spc_pkg::*;

    logic [`SPC_CTRL_W-1:0] ctrl_q;
    logic [`SPC_MODE_W-1:0] mode_q;
    logic                   mpb_q;
    apb_state_t             apb_q;
    logic                   hit;
    logic                   acc;
    logic                   wr;
    logic [`SPC_DW-1:0]     rdata_d;
    comm_mode_t             comm;
    logic [1:0]             cks;
    sck_role_t              role;
    logic                   mp_active;
    logic                   rx_take;
    logic                   discard;
    logic                   wake;
    logic                   pass;
    logic [`SPC_NEV-1:0]    ev;
    logic [`SPC_NEV-1:0]    istat;
    logic [`SPC_NEV-1:0]    ien;
    logic [`SPC_ST_W-1:0]   state;

    // Bus decode
    assign hit = (PADDR == `SPC_OFS_CTRL) || (PADDR == `SPC_OFS_MODE)
              || (PADDR == `SPC_OFS_STATE) || (PADDR == `SPC_OFS_ISTAT)
              || (PADDR == `SPC_OFS_IEN) || (PADDR == `SPC_OFS_ICLR);
    assign acc = PSEL && PENABLE && (apb_q == APB_ANSWER);
    assign wr  = acc && PWRITE && hit;

    // Answer one cycle into the access phase
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            apb_q   <= APB_SETUP;
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= '0;
        end else if (CE) begin
            case (apb_q)
                APB_SETUP: begin
                    if (PSEL && PENABLE) begin
                        apb_q   <= APB_ANSWER;
                        PREADY  <= 1'b1;
                        PSLVERR <= !hit;
                        PRDATA  <= PWRITE ? '0 : rdata_d;
                    end
                end
                APB_ANSWER: begin
                    apb_q   <= APB_SETUP;
                    PREADY  <= 1'b0;
                    PSLVERR <= 1'b0;
                    PRDATA  <= '0;
                end
                default: begin
                    apb_q  <= APB_SETUP;
                    PREADY <= 1'b0;
                end
            endcase
        end
    end

    always_comb begin
        rdata_d = '0;
        case (PADDR)
            `SPC_OFS_CTRL:  rdata_d[`SPC_CTRL_W-1:0] = ctrl_q;
            `SPC_OFS_MODE:  rdata_d[`SPC_MODE_W-1:0] = mode_q;
            `SPC_OFS_STATE: rdata_d[`SPC_ST_W-1:0]   = state;
            `SPC_OFS_ISTAT: rdata_d[`SPC_NEV-1:0]    = istat;
            `SPC_OFS_IEN:   rdata_d[`SPC_NEV-1:0]    = ien;
            default:        rdata_d = '0;
        endcase
    end

    assign state[`SPC_ST_MPB]   = mpb_q;
    assign state[`SPC_ST_TXE]   = TX_EMPTY;
    assign state[`SPC_ST_TXEND] = TX_END;
    assign state[`SPC_ST_EXT]   = CLK_EXTERNAL;

    // Wake-up filter state
    // filter scope
    assign comm      = comm_mode_t'(mode_q[`SPC_MODE_COM]);
    assign mp_active = ctrl_q[`SPC_BIT_MULTIPROC_WAKEUP_ENABLE] && mode_q[`SPC_MODE_MP]
                    && (comm == COMM_ASYNC);
    assign rx_take   = RX_DONE && ctrl_q[`SPC_BIT_RE];
    assign discard   = rx_take && mp_active && !RX_MPB;
    assign wake      = rx_take && mp_active && RX_MPB;
    assign pass      = rx_take && !discard;

    // Software write beats the self clear in the same cycle
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ctrl_q <= `SPC_CTRL_RST;
        end else if (CE) begin
            if (wr && PADDR == `SPC_OFS_CTRL) begin
                ctrl_q <= PWDATA[`SPC_CTRL_W-1:0];
            end else if (wake) begin
                ctrl_q[`SPC_BIT_MULTIPROC_WAKEUP_ENABLE] <= 1'b0;
            end
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            mode_q <= `SPC_MODE_RST;
        end else if (CE && wr && PADDR == `SPC_OFS_MODE) begin
            mode_q <= PWDATA[`SPC_MODE_W-1:0];
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            mpb_q <= 1'b0;
        end else if (CE && rx_take) begin
            mpb_q <= RX_MPB;
        end
    end

    // Status flag strobes to the framing logic
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            RX_FULL_SET <= 1'b0;
            FER_SET     <= 1'b0;
            OVR_SET     <= 1'b0;
        end else if (CE) begin
            RX_FULL_SET <= pass && !RX_FER && !RX_OVR;
            FER_SET     <= pass && RX_FER;
            OVR_SET     <= pass && RX_OVR;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            TX_ENABLE <= 1'b0;
            RX_ENABLE <= 1'b0;
        end else if (CE) begin
            TX_ENABLE <= ctrl_q[`SPC_BIT_TE];
            RX_ENABLE <= ctrl_q[`SPC_BIT_RE];
        end
    end

    // Interrupt requests
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            TX_EMPTY_IRQ <= 1'b0;
            RX_FULL_IRQ  <= 1'b0;
            RX_ERROR_IRQ <= 1'b0;
            TX_END_IRQ   <= 1'b0;
        end else if (CE) begin
            TX_EMPTY_IRQ <= ctrl_q[`SPC_BIT_TIE] && TX_EMPTY;
            RX_FULL_IRQ  <= ctrl_q[`SPC_BIT_RIE] && RX_FULL_LVL;
            RX_ERROR_IRQ <= ctrl_q[`SPC_BIT_RIE] && RX_ERR_LVL;
            TX_END_IRQ   <= ctrl_q[`SPC_BIT_TX_END_IRQ_ENABLE] && TX_END;
        end
    end

    assign ev[`SPC_EV_TXE]   = TX_EMPTY_IRQ;
    assign ev[`SPC_EV_RXF]   = RX_FULL_IRQ;
    assign ev[`SPC_EV_RXE]   = RX_ERROR_IRQ;
    assign ev[`SPC_EV_TXEND] = TX_END_IRQ;

    spc_irq_unit #(
        .N        (`SPC_NEV)
    ) u_irq (
        .clk      (CORE_CLK),
        .rst_n    (RST_N),
        .ce       (CE),
        .set_ev   (ev),
        .en_wr    (wr && PADDR == `SPC_OFS_IEN),
        .clr_wr   (wr && PADDR == `SPC_OFS_ICLR),
        .wdata    (PWDATA[`SPC_NEV-1:0]),
        .status_q (istat),
        .enable_q (ien),
        .irq_q    (IRQ)
    );

    // Clock source selection
    assign cks = {ctrl_q[`SPC_BIT_CLOCK_SOURCE_HI], ctrl_q[`SPC_BIT_CLOCK_SOURCE_LO]};

    always_comb begin
        role = SCK_INT_ONLY;
        if (comm == COMM_SYNC) begin
            // reserved sync codes act as code 00
            role = (cks == `SPC_CKS_EXT) ? SCK_EXT_IN : SCK_INT_DRIVE;
        end else begin
            case (cks)
                `SPC_CKS_INT_OUT: role = SCK_INT_DRIVE;
                `SPC_CKS_EXT:     role = SCK_EXT_IN;
                default:          role = SCK_INT_ONLY;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            CLK_EXTERNAL <= 1'b0;
        end else if (CE) begin
            CLK_EXTERNAL <= (role == SCK_EXT_IN);
        end
    end

    spc_sck_unit u_sck (
        .clk       (CORE_CLK),
        .rst_n     (RST_N),
        .ce        (CE),
        .role      (role),
        .bit_tick  (BIT_TICK),
        .sck_i     (SCK_I),
        .sck_o     (SCK_O),
        .sck_oe    (SCK_OE),
        .xfer_tick (XFER_TICK)
    );

    // Checks
    txe_irq_gate_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        $rose(TX_EMPTY_IRQ) |-> $past(ctrl_q[`SPC_BIT_TIE]) && $past(TX_EMPTY))
        else $error("transmit empty request without enable");
    rx_irq_gate_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        CE && !ctrl_q[`SPC_BIT_RIE] |=> !RX_FULL_IRQ && !RX_ERROR_IRQ)
        else $error("receive request without enable");
    tx_en_follow_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        CE |=> TX_ENABLE == $past(ctrl_q[`SPC_BIT_TE]))
        else $error("transmit enable does not follow control");
    rx_off_gate_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        CE && RX_DONE && !ctrl_q[`SPC_BIT_RE] |=> !RX_FULL_SET && !FER_SET && !OVR_SET)
        else $error("flags set while receiver off");
    mp_scope_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        CE && rx_take && (comm == COMM_SYNC) && !RX_FER && !RX_OVR |=> RX_FULL_SET)
        else $error("filter active outside async mode");
    mp_discard_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        CE && discard |=> !RX_FULL_SET && !FER_SET && !OVR_SET)
        else $error("filtered character set a flag");
    mp_wake_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        CE && wake && !wr && !RX_FER && !RX_OVR |=> !ctrl_q[`SPC_BIT_MULTIPROC_WAKEUP_ENABLE] && RX_FULL_SET)
        else $error("wake did not clear filter");
    tx_end_gate_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        CE && !ctrl_q[`SPC_BIT_TX_END_IRQ_ENABLE] |=> !TX_END_IRQ)
        else $error("transmit end request without enable");
    async_int_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        CE && comm == COMM_ASYNC && cks == `SPC_CKS_INT |=> !SCK_OE && !CLK_EXTERNAL)
        else $error("async code 00 misrouted");
    async_drive_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        CE && comm == COMM_ASYNC && cks == `SPC_CKS_INT_OUT |=> SCK_OE && !CLK_EXTERNAL)
        else $error("async code 01 misrouted");
    async_ext_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        CE && comm == COMM_ASYNC && cks == `SPC_CKS_EXT |=> !SCK_OE && CLK_EXTERNAL)
        else $error("async code 10 misrouted");
    sync_ext_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        CE && comm == COMM_SYNC && cks == `SPC_CKS_EXT |=> !SCK_OE && CLK_EXTERNAL)
        else $error("sync code 10 misrouted");
    sync_reserved_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        CE && comm == COMM_SYNC && cks[0] |=> SCK_OE && !CLK_EXTERNAL)
        else $error("reserved sync code not driving clock");
    mpb_hold_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        !ctrl_q[`SPC_BIT_RE] |=> $stable(mpb_q))
        else $error("held multiprocessor bit changed");

    wake_c: cover property (@(posedge CORE_CLK) disable iff (!RST_N) CE && wake);
    discard_c: cover property (@(posedge CORE_CLK) disable iff (!RST_N) CE && discard);
    irq_c: cover property (@(posedge CORE_CLK) disable iff (!RST_N) $rose(IRQ));
    sync_ext_c: cover property (@(posedge CORE_CLK) disable iff (!RST_N)
        CE && CLK_EXTERNAL && comm == COMM_SYNC);
endmodule

//--- tb/spc_far_end.sv
// Purpose: Remote serial party: character reports and pin clock
// Assumes: Driven from the bench through its tasks
// Notes:   Pin clock stands still high outside bursts
module spc_far_end (
    // Clock
    input  wire logic clk,
    // Character report
    output logic      rx_done,
    output logic      rx_mpb,
    output logic      rx_fer,
    output logic      rx_ovr,
    // Pin clock
    output logic      pin_clk
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        rx_done = 1'b0;
        {rx_mpb, rx_fer, rx_ovr} = 3'h0;
        pin_clk = 1'b1;
    end

    task automatic send(input logic [2:0] c);
        @(posedge clk);
        rx_done <= 1'b1;
        {rx_mpb, rx_fer, rx_ovr} <= c;
        @(posedge clk);
        rx_done <= 1'b0;
        // Qualifiers are junk once the pulse is gone
        {rx_mpb, rx_fer, rx_ovr} <= ~c;
    endtask

    task automatic burst(input int n);
        repeat (n) begin
            repeat (3) @(posedge clk);
            pin_clk <= 1'b0;
            repeat (3) @(posedge clk);
            pin_clk <= 1'b1;
        end
    endtask
endmodule

//--- tb/serial_port_control_tb_top.sv
// Purpose: Self-checking bench of the serial port control block
// Assumes: APB reads are judged by a watcher against queued notes
// Notes:   CE drops once to show that state freezes
`include "spc_defs.svh"

module serial_port_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [7:0] oe_tab  = 8'hb2;
    localparam logic [7:0] ext_tab = 8'h44;
    localparam logic [7:0] ien [4] = '{8'h00, 8'h80, 8'h40, 8'h04};
    localparam logic [3:0] iexp [4] = '{4'h0, 4'h8, 4'h6, 4'h1};

    logic        CORE_CLK, RST_N, CE, PSEL, PENABLE, PWRITE, BIT_TICK;
    logic        TX_EMPTY, TX_END, RX_FULL_LVL, RX_ERR_LVL;
    logic [7:0]  PADDR;
    logic [31:0] PWDATA;
    wire  logic [31:0] PRDATA;
    wire  logic  PREADY, PSLVERR, SCK_I, SCK_O, SCK_OE, TX_ENABLE, RX_ENABLE, XFER_TICK;
    wire  logic  CLK_EXTERNAL, RX_FULL_SET, FER_SET, OVR_SET, IRQ;
    wire  logic  TX_EMPTY_IRQ, RX_FULL_IRQ, RX_ERROR_IRQ, TX_END_IRQ;
    wire  logic  RX_DONE, RX_MPB, RX_FER, RX_OVR, pin_clk;
    logic [32:0] notes [$];
    logic        sk_prev = 1'b1;
    int          miscompares = 0, checks_done = 0, xt_n = 0, sk_n = 0, x0, s0;
    logic [7:0]  r;

    assign SCK_I = SCK_OE ? SCK_O : pin_clk;

    serial_port_control serial_port_control_i (.CORE_CLK(CORE_CLK), .RST_N(RST_N),
        .CE(CE), .PADDR(PADDR), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .TX_EMPTY(TX_EMPTY), .TX_END(TX_END), .RX_DONE(RX_DONE), .RX_MPB(RX_MPB),
        .RX_FER(RX_FER), .RX_OVR(RX_OVR), .RX_FULL_LVL(RX_FULL_LVL),
        .RX_ERR_LVL(RX_ERR_LVL), .BIT_TICK(BIT_TICK), .SCK_I(SCK_I), .SCK_O(SCK_O),
        .SCK_OE(SCK_OE), .TX_ENABLE(TX_ENABLE), .RX_ENABLE(RX_ENABLE),
        .XFER_TICK(XFER_TICK), .CLK_EXTERNAL(CLK_EXTERNAL), .RX_FULL_SET(RX_FULL_SET),
        .FER_SET(FER_SET), .OVR_SET(OVR_SET), .TX_EMPTY_IRQ(TX_EMPTY_IRQ),
        .RX_FULL_IRQ(RX_FULL_IRQ), .RX_ERROR_IRQ(RX_ERROR_IRQ),
        .TX_END_IRQ(TX_END_IRQ), .IRQ(IRQ));

    spc_far_end spc_far_end_i (.clk(CORE_CLK), .rx_done(RX_DONE), .rx_mpb(RX_MPB),
        .rx_fer(RX_FER), .rx_ovr(RX_OVR), .pin_clk(pin_clk));

    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        if (miscompares == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge CORE_CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CORE_CLK);
        PENABLE <= 1'b1;
        do begin
            @(posedge CORE_CLK);
            n++;
        end while (PREADY !== 1'b1 && n < 20);
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        if (n == 20)
            miscompares++;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        notes.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge CORE_CLK);
        @(negedge CORE_CLK);
    endtask

    task automatic rx(input logic [2:0] c, input logic [2:0] e);
        spc_far_end_i.send(c);
        @(negedge CORE_CLK);
        chk({RX_FULL_SET, FER_SET, OVR_SET}, e);
    endtask

    // Read answers are judged where they appear
    always @(posedge CORE_CLK) begin
        if (PSEL && PENABLE && PREADY === 1'b1 && !PWRITE)
            chk({PSLVERR, PRDATA}, notes.pop_front());
        xt_n <= xt_n + int'(XFER_TICK === 1'b1);
        // Only a driven pin counts as clock activity
        sk_n <= sk_n + int'(SCK_OE === 1'b1 && SCK_O !== sk_prev);
        sk_prev <= SCK_O;
    end

    initial begin
        CORE_CLK = 1'b0;
        forever #5 CORE_CLK = ~CORE_CLK;
    end

    initial begin
        #300000;
        miscompares++;
        close_out();
    end

    initial begin
        {RST_N, PSEL, PENABLE, PWRITE, BIT_TICK} = 5'h0;
        CE = 1'b1;
        {TX_EMPTY, TX_END, RX_FULL_LVL, RX_ERR_LVL} = 4'h0;
        PADDR = 8'h00;
        PWDATA = 32'h0;
        void'($urandom(32'hdd60293c));
        repeat (20) @(posedge CORE_CLK);
        chk({SCK_O, SCK_OE}, 2'b10);
        RST_N <= 1'b1;
        rd(`SPC_OFS_CTRL, 33'h0);
        rd(`SPC_OFS_MODE, 33'h0);
        rd(`SPC_OFS_ISTAT, 33'h0);
        rd(8'h18, {1'b1, 32'h0});
        repeat (4) begin
            r = 8'($urandom()) & 8'hf4;
            wr(`SPC_OFS_CTRL, {24'h0, r});
            rd(`SPC_OFS_CTRL, {25'h0, r});
            settle(3);
            chk({TX_ENABLE, RX_ENABLE}, r[5:4]);
        end
        // Sources held up while each enable is tried alone
        {TX_EMPTY, TX_END, RX_FULL_LVL, RX_ERR_LVL} <= 4'hf;
        for (int i = 0; i < 4; i++) begin
            wr(`SPC_OFS_CTRL, {24'h0, ien[i]});
            settle(3);
            chk({TX_EMPTY_IRQ, RX_FULL_IRQ, RX_ERROR_IRQ, TX_END_IRQ}, iexp[i]);
        end
        rd(`SPC_OFS_ISTAT, 33'hf);
        chk(IRQ, 1'b0);
        wr(`SPC_OFS_IEN, 32'h2);
        settle(3);
        chk(IRQ, 1'b1);
        {TX_EMPTY, TX_END, RX_FULL_LVL, RX_ERR_LVL} <= 4'h0;
        wr(`SPC_OFS_CTRL, 32'h0);
        wr(`SPC_OFS_ICLR, 32'h2);
        rd(`SPC_OFS_ISTAT, 33'hd);
        settle(3);
        chk(IRQ, 1'b0);
        wr(`SPC_OFS_ICLR, 32'hf);
        rd(`SPC_OFS_ISTAT, 33'h0);
        wr(`SPC_OFS_CTRL, 32'h10);
        rx(3'b000, 3'b100);
        rx(3'b010, 3'b010);
        rx(3'b001, 3'b001);
        // Frozen clock enable swallows a character
        settle(1);
        CE <= 1'b0;
        rx(3'b000, 3'b000);
        CE <= 1'b1;
        wr(`SPC_OFS_MODE, 32'h2);
        wr(`SPC_OFS_CTRL, 32'h18);
        rx(3'b010, 3'b000);
        rx(3'b001, 3'b000);
        rx(3'b100, 3'b100);
        rd(`SPC_OFS_CTRL, 33'h10);
        rd(`SPC_OFS_STATE, 33'h1);
        wr(`SPC_OFS_MODE, 32'h3);
        wr(`SPC_OFS_CTRL, 32'h18);
        rx(3'b000, 3'b100);
        rx(3'b100, 3'b100);
        wr(`SPC_OFS_CTRL, 32'h0);
        rx(3'b000, 3'b000);
        rd(`SPC_OFS_STATE, 33'h1);
        // Every mode and clock code, reserved ones included
        for (int i = 0; i < 8; i++) begin
            wr(`SPC_OFS_MODE, {31'h0, i[2]});
            wr(`SPC_OFS_CTRL, {30'h0, i[1:0]});
            settle(3);
            chk({SCK_OE, CLK_EXTERNAL}, {oe_tab[i], ext_tab[i]});
            x0 = xt_n;
            s0 = sk_n;
            if (ext_tab[i])
                spc_far_end_i.burst(4);
            else
                repeat (4) begin
                    @(posedge CORE_CLK);
                    BIT_TICK <= 1'b1;
                    @(posedge CORE_CLK);
                    BIT_TICK <= 1'b0;
                end
            settle(8);
            chk(33'(xt_n - x0), 33'd4);
            chk(33'(sk_n - s0), oe_tab[i] ? 33'd4 : 33'd0);
        end
        close_out();
    end
endmodule
